// >>> core/bmcd_pkg.sv
// constants for the branch / multiply / stack instruction decoder
package bmcd_pkg;
   localparam logic [15:0] OP_BR_AUX_NZ = 16'hf400;
   localparam logic [15:0] OP_BR_NEG = 16'hfa00;
   localparam logic [15:0] OP_BR_ZERO = 16'hff00;
   localparam logic [15:0] OP_SUB_EXIT = 16'h7f8d;
   localparam logic [15:0] OP_ADD_PRODUCT_TO_ACC = 16'h7f8f;
   localparam logic [15:0] OP_PAC = 16'h7f8e;
   localparam logic [15:0] OP_SUBTRACT_PRODUCT_FROM_ACC = 16'h7f90;
   localparam logic [15:0] OP_POP = 16'h7f9d;
   localparam logic [15:0] OP_PUSH = 16'h7f9c;
   localparam logic [7:0] HI_LTA = 8'h6c;
   localparam logic [7:0] HI_LTD = 8'h6b;
   localparam logic [7:0] HI_MPY = 8'h6d;
   localparam logic [2:0] TOP_MULTIPLY_BY_IMMEDIATE = 3'h4;
   localparam int HI_POS = 8;
   localparam int TOP_POS = 13;
   localparam int IMM_W = 13;
   localparam int ADDR_W = 12;
   localparam int MODE_BIT = 7;
   localparam int INC_BIT = 5;
   localparam int DEC_BIT = 4;
   localparam int ARP_BIT = 0;
   localparam int DADDR_W = 7;
   localparam logic [3:0] TGT_TOP = 4'h0;
   localparam logic [ADDR_W-1:0] PC_RESET = 12'h000;
   // decoded operation classes
   typedef enum logic [3:0] {
      BMCD_OP_NONE = 4'h0, BMCD_OP_BRANCH_ON_AUX_NONZERO = 4'h1, BMCD_OP_BNEG = 4'h2, BMCD_OP_BZ = 4'h3,
      BMCD_OP_RET = 4'h4, BMCD_OP_ADD_PRODUCT_TO_ACC = 4'h5, BMCD_OP_LTA = 4'h6, BMCD_OP_LTD = 4'h7,
      BMCD_OP_MPY = 4'h8, BMCD_OP_MULTIPLY_BY_IMMEDIATE = 4'h9, BMCD_OP_PAC = 4'ha, BMCD_OP_SUBTRACT_PRODUCT_FROM_ACC = 4'hb,
      BMCD_OP_POP = 4'hc, BMCD_OP_PUSH = 4'hd
   } bmcd_op_t;
endpackage

// >>> core/bmcd_decode.sv
// combinational opcode classifier
`timescale 1ns/1ps
`default_nettype none
module bmcd_decode (
   input wire logic [15:0] i_word,
   output var bmcd_pkg::bmcd_op_t o_op,
   output logic o_uses_data
);
   wire [7:0] hi = i_word[15:bmcd_pkg::HI_POS];
   wire [2:0] top = i_word[15:bmcd_pkg::TOP_POS];
   always_comb begin
      o_op = bmcd_pkg::BMCD_OP_NONE;
      if (i_word == bmcd_pkg::OP_BR_AUX_NZ) o_op = bmcd_pkg::BMCD_OP_BRANCH_ON_AUX_NONZERO;
      else if (i_word == bmcd_pkg::OP_BR_NEG) o_op = bmcd_pkg::BMCD_OP_BNEG;
      else if (i_word == bmcd_pkg::OP_BR_ZERO) o_op = bmcd_pkg::BMCD_OP_BZ;
      else if (i_word == bmcd_pkg::OP_SUB_EXIT) o_op = bmcd_pkg::BMCD_OP_RET;
      else if (i_word == bmcd_pkg::OP_ADD_PRODUCT_TO_ACC) o_op = bmcd_pkg::BMCD_OP_ADD_PRODUCT_TO_ACC;
      else if (i_word == bmcd_pkg::OP_PAC) o_op = bmcd_pkg::BMCD_OP_PAC;
      else if (i_word == bmcd_pkg::OP_SUBTRACT_PRODUCT_FROM_ACC) o_op = bmcd_pkg::BMCD_OP_SUBTRACT_PRODUCT_FROM_ACC;
      else if (i_word == bmcd_pkg::OP_POP) o_op = bmcd_pkg::BMCD_OP_POP;
      else if (i_word == bmcd_pkg::OP_PUSH) o_op = bmcd_pkg::BMCD_OP_PUSH;
      else if (hi == bmcd_pkg::HI_LTA) o_op = bmcd_pkg::BMCD_OP_LTA;
      else if (hi == bmcd_pkg::HI_LTD) o_op = bmcd_pkg::BMCD_OP_LTD;
      else if (hi == bmcd_pkg::HI_MPY) o_op = bmcd_pkg::BMCD_OP_MPY;
      else if (top == bmcd_pkg::TOP_MULTIPLY_BY_IMMEDIATE) o_op = bmcd_pkg::BMCD_OP_MULTIPLY_BY_IMMEDIATE;
   end
   assign o_uses_data = (o_op == bmcd_pkg::BMCD_OP_LTA) || (o_op == bmcd_pkg::BMCD_OP_LTD) ||
                        (o_op == bmcd_pkg::BMCD_OP_MPY);
endmodule
`default_nettype wire

// >>> core/bmcd_aux_update.sv
// indirect-mode auxiliary register update
`timescale 1ns/1ps
`default_nettype none
module bmcd_aux_update #(
   parameter int AUX_W = 16
) (
   input wire logic [15:0] i_word,
   input wire logic i_data_op,
   input wire logic [AUX_W-1:0] i_aux_val,
   output logic o_aux_we,
   output logic [AUX_W-1:0] o_aux_new
);
   wire indirect = i_data_op && i_word[bmcd_pkg::MODE_BIT];
   wire inc = i_word[bmcd_pkg::INC_BIT];
   wire dec = i_word[bmcd_pkg::DEC_BIT];
   // increment wins if both bits are set
   assign o_aux_we = indirect && (inc || dec);
   assign o_aux_new = inc ? i_aux_val + AUX_W'(1) : i_aux_val - AUX_W'(1);
endmodule
`default_nettype wire

// >>> core/bmcd_top.sv
// sequencer for branch, return, product and stack instructions
`timescale 1ns/1ps
`default_nettype none
module bmcd_top #(
   parameter int AUX_W = 16,
   parameter int ACC_W = 32
) (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_ce,
   input wire logic [15:0] i_prog_word,
   input wire logic i_acc_neg,
   input wire logic i_acc_zero,
   input wire logic [AUX_W-1:0] i_aux0,
   input wire logic [AUX_W-1:0] i_aux1,
   input wire logic [bmcd_pkg::ADDR_W-1:0] i_stack_top,
   output logic [bmcd_pkg::ADDR_W-1:0] o_pc,
   output logic o_busy,
   output logic o_acc_add_p,
   output logic o_acc_sub_p,
   output logic o_acc_load_p,
   output logic o_acc_from_stack,
   output logic o_stack_push_acc,
   output logic o_stack_pop_pc,
   output logic o_load_t,
   output logic o_data_move,
   output logic o_mul_data,
   output logic o_mul_imm,
   output logic [bmcd_pkg::IMM_W-1:0] o_imm,
   output logic [bmcd_pkg::DADDR_W-1:0] o_daddr,
   output logic o_indirect,
   output logic o_aux_we,
   output logic o_aux_sel,
   output logic [AUX_W-1:0] o_aux_new
);
   // one-hot sequencer: fetch, branch target word, second cycle of two-cycle ops
   typedef enum logic [2:0] {
      ST_FETCH = 3'h1,
      ST_TARGET = 3'h2,
      ST_SECOND = 3'h4
   } bmcd_state_t;

   bmcd_state_t state_reg, state_next;
   bmcd_pkg::bmcd_op_t op_reg, op_next;
   bmcd_pkg::bmcd_op_t dec_op;
   logic dec_data;
   logic [bmcd_pkg::ADDR_W-1:0] pc_reg, pc_next;
   logic arp_reg, arp_next;
   logic aux_we_w;
   logic [AUX_W-1:0] aux_new_w;
   logic [15:0] pulse_next, pulse_reg;
   logic [bmcd_pkg::IMM_W-1:0] imm_reg, imm_next;
   logic [bmcd_pkg::DADDR_W-1:0] daddr_reg, daddr_next;
   logic ind_reg, ind_next, awe_reg, asel_reg;
   logic [AUX_W-1:0] anew_reg;

   bmcd_decode u_dec (
      .i_word(i_prog_word),
      .o_op(dec_op),
      .o_uses_data(dec_data)
   );

   wire in_fetch = (state_reg == ST_FETCH);
   wire [AUX_W-1:0] aux_cur = arp_reg ? i_aux1 : i_aux0;

   bmcd_aux_update #(.AUX_W(AUX_W)) u_aux (
      .i_word(i_prog_word),
      .i_data_op(in_fetch && dec_data),
      .i_aux_val(aux_cur),
      .o_aux_we(aux_we_w),
      .o_aux_new(aux_new_w)
   );

   wire is_branch = (dec_op == bmcd_pkg::BMCD_OP_BRANCH_ON_AUX_NONZERO) || (dec_op == bmcd_pkg::BMCD_OP_BNEG) ||
                    (dec_op == bmcd_pkg::BMCD_OP_BZ);
   wire is_two = (dec_op == bmcd_pkg::BMCD_OP_RET) || (dec_op == bmcd_pkg::BMCD_OP_POP) ||
                 (dec_op == bmcd_pkg::BMCD_OP_PUSH);
   wire tgt_ok = (i_prog_word[15:bmcd_pkg::ADDR_W] == bmcd_pkg::TGT_TOP);
   wire [bmcd_pkg::ADDR_W-1:0] tgt = i_prog_word[bmcd_pkg::ADDR_W-1:0];
   wire [bmcd_pkg::ADDR_W-1:0] pc_inc = pc_reg + bmcd_pkg::ADDR_W'(1);

   wire taken = ((op_reg == bmcd_pkg::BMCD_OP_BRANCH_ON_AUX_NONZERO) && (aux_cur != '0)) ||
                ((op_reg == bmcd_pkg::BMCD_OP_BNEG) && i_acc_neg) ||
                ((op_reg == bmcd_pkg::BMCD_OP_BZ) && i_acc_zero);

   always_comb begin
      state_next = state_reg;
      op_next = op_reg;
      pc_next = pc_reg;
      arp_next = arp_reg;
      pulse_next = '0;
      imm_next = imm_reg;
      daddr_next = daddr_reg;
      ind_next = 1'b0;
      case (state_reg)
         ST_FETCH: begin
            op_next = dec_op;
            pc_next = pc_inc;
            daddr_next = i_prog_word[bmcd_pkg::DADDR_W-1:0];
            ind_next = dec_data && i_prog_word[bmcd_pkg::MODE_BIT];
            if (is_branch) begin
               state_next = ST_TARGET;
            end else if (is_two) begin
               state_next = ST_SECOND;
            end else begin
               // single-cycle ops fire their strobe in the cycle after fetch
               pulse_next[dec_op] = (dec_op != bmcd_pkg::BMCD_OP_NONE);
               if (dec_op == bmcd_pkg::BMCD_OP_MULTIPLY_BY_IMMEDIATE) begin
                  imm_next = i_prog_word[bmcd_pkg::IMM_W-1:0];
               end
               // pointer select bit follows any indirect data access, modified or not
               if (ind_next) begin
                  arp_next = i_prog_word[bmcd_pkg::ARP_BIT];
               end
            end
         end
         ST_TARGET: begin
            state_next = ST_FETCH;
            // load target or skip over the target word
            pc_next = (taken && tgt_ok) ? tgt : pc_inc;
            if (op_reg == bmcd_pkg::BMCD_OP_BRANCH_ON_AUX_NONZERO) begin
               pulse_next[bmcd_pkg::BMCD_OP_BRANCH_ON_AUX_NONZERO] = 1'b1;
            end
         end
         ST_SECOND: begin
            state_next = ST_FETCH;
            // return reloads pc from stack top
            if (op_reg == bmcd_pkg::BMCD_OP_RET) begin
               pc_next = i_stack_top;
            end
            pulse_next[op_reg] = 1'b1;
         end
         default: begin
            state_next = ST_FETCH;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         state_reg <= ST_FETCH;
         op_reg <= bmcd_pkg::BMCD_OP_NONE;
         pc_reg <= bmcd_pkg::PC_RESET;
         arp_reg <= 1'b0;
         pulse_reg <= '0;
         imm_reg <= '0;
         daddr_reg <= '0;
         ind_reg <= 1'b0;
      end else if (i_ce) begin
         state_reg <= state_next;
         op_reg <= op_next;
         pc_reg <= pc_next;
         arp_reg <= arp_next;
         pulse_reg <= pulse_next;
         imm_reg <= imm_next;
         daddr_reg <= daddr_next;
         ind_reg <= ind_next;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         awe_reg <= 1'b0;
         asel_reg <= 1'b0;
         anew_reg <= '0;
      end else if (i_ce) begin
         awe_reg <= aux_we_w || (state_reg == ST_TARGET && op_reg == bmcd_pkg::BMCD_OP_BRANCH_ON_AUX_NONZERO);
         asel_reg <= arp_reg;
         anew_reg <= aux_we_w ? aux_new_w : aux_cur - AUX_W'(1);
      end
   end

   assign o_pc = pc_reg;
   assign o_busy = !in_fetch;
   // add P, also LOAD_T_AND_ACCUMULATE_PRODUCT and LTD
   assign o_acc_add_p = pulse_reg[bmcd_pkg::BMCD_OP_ADD_PRODUCT_TO_ACC] || pulse_reg[bmcd_pkg::BMCD_OP_LTA] ||
                        pulse_reg[bmcd_pkg::BMCD_OP_LTD];
   assign o_acc_sub_p = pulse_reg[bmcd_pkg::BMCD_OP_SUBTRACT_PRODUCT_FROM_ACC];
   assign o_acc_load_p = pulse_reg[bmcd_pkg::BMCD_OP_PAC];
   assign o_acc_from_stack = pulse_reg[bmcd_pkg::BMCD_OP_POP];
   assign o_stack_push_acc = pulse_reg[bmcd_pkg::BMCD_OP_PUSH];
   assign o_stack_pop_pc = pulse_reg[bmcd_pkg::BMCD_OP_RET];
   // load T for LOAD_T_AND_ACCUMULATE_PRODUCT, and LTD
   assign o_load_t = pulse_reg[bmcd_pkg::BMCD_OP_LTA] || pulse_reg[bmcd_pkg::BMCD_OP_LTD];
   assign o_data_move = pulse_reg[bmcd_pkg::BMCD_OP_LTD];
   assign o_mul_data = pulse_reg[bmcd_pkg::BMCD_OP_MPY];
   assign o_mul_imm = pulse_reg[bmcd_pkg::BMCD_OP_MULTIPLY_BY_IMMEDIATE];
   assign o_imm = imm_reg;
   assign o_daddr = daddr_reg;
   assign o_indirect = ind_reg;
   assign o_aux_we = awe_reg;
   assign o_aux_sel = asel_reg;
   assign o_aux_new = anew_reg;

   // branch always spends exactly the target cycle
   chk_branch_two_cycle: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (in_fetch && i_ce && is_branch) |=> (state_reg == ST_TARGET));
   chk_untaken_skip: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (state_reg == ST_TARGET && i_ce && !taken) |=> (pc_reg == $past(pc_reg) + 12'h001));
   chk_taken_load: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (state_reg == ST_TARGET && i_ce && taken && tgt_ok) |=> (pc_reg == $past(tgt)));
   chk_ret_pop: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (in_fetch && i_ce && dec_op == bmcd_pkg::BMCD_OP_RET) ##1 i_ce |=> o_stack_pop_pc);
   chk_add_product_to_acc_one: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (in_fetch && i_ce && dec_op == bmcd_pkg::BMCD_OP_ADD_PRODUCT_TO_ACC) |=> (o_acc_add_p && in_fetch));
   chk_multiply_by_immediate_imm: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (in_fetch && i_ce && dec_op == bmcd_pkg::BMCD_OP_MULTIPLY_BY_IMMEDIATE) |=> (o_mul_imm && o_imm == $past(i_prog_word[12:0])));
   chk_push_two: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (in_fetch && i_ce && dec_op == bmcd_pkg::BMCD_OP_PUSH) |=> (!o_stack_push_acc && o_busy));
   chk_sub_excl: assert property (@(posedge i_clk) disable iff (!i_resetn)
      !(o_acc_sub_p && o_acc_add_p));
   chk_aux_inc: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (in_fetch && i_ce && dec_data && i_prog_word[7] && i_prog_word[5]) |=> (o_aux_we && o_aux_new == $past(aux_cur) + 16'h0001));
endmodule
`default_nettype wire

// >>> test/bmcd_prog_mem.sv
// combinational program memory feeding instruction words to the decoder
`timescale 1ns/1ps
`default_nettype none
module bmcd_prog_mem (
   input wire logic [11:0] i_addr,
   output logic [15:0] o_word
);
   logic [15:0] mem [0:4095];
   // unwritten words read as the no-operation code, so a stray fetch stays harmless
   initial begin
      for (int a = 0; a < 4096; a++) begin
         mem[a] = 16'h7f80;
      end
   end
   assign o_word = mem[i_addr];
endmodule
`default_nettype wire

// >>> test/branch_multiply_control_decoder_bench.sv
// self-checking bench for the branch / multiply / stack decoder
`timescale 1ns/1ps
`default_nettype none
module branch_multiply_control_decoder_bench;
   logic i_clk = 1'b0;
   logic i_resetn = 1'b0;
   logic i_ce = 1'b1;
   logic i_acc_neg = 1'b0;
   logic i_acc_zero = 1'b0;
   logic [15:0] i_aux0 = 16'h0000;
   logic [15:0] i_aux1 = 16'h0000;
   logic [11:0] i_stack_top = 12'h000;
   logic [15:0] prog_word, aux_new;
   logic [11:0] pc;
   logic [12:0] imm;
   logic [6:0] daddr;
   logic busy, add_p, sub_p, load_p, from_stack, push_acc, pop_pc, load_t, data_move, mul_data, mul_imm;
   logic indirect, aux_we, aux_sel;
   logic [9:0] pulses;
   int failures = 0;
   int samples_checked = 0;
   int cycles = 0;
   assign pulses = {add_p, sub_p, load_p, from_stack, push_acc, pop_pc, load_t, data_move, mul_data, mul_imm};
   bmcd_prog_mem u_bmcd_prog_mem (.i_addr(pc), .o_word(prog_word));
   bmcd_top #(.AUX_W(16), .ACC_W(32)) u_bmcd_top (
      .i_clk(i_clk), .i_resetn(i_resetn), .i_ce(i_ce), .i_prog_word(prog_word), .i_acc_neg(i_acc_neg),
      .i_acc_zero(i_acc_zero), .i_aux0(i_aux0), .i_aux1(i_aux1), .i_stack_top(i_stack_top), .o_pc(pc),
      .o_busy(busy), .o_acc_add_p(add_p), .o_acc_sub_p(sub_p), .o_acc_load_p(load_p),
      .o_acc_from_stack(from_stack), .o_stack_push_acc(push_acc), .o_stack_pop_pc(pop_pc), .o_load_t(load_t),
      .o_data_move(data_move), .o_mul_data(mul_data), .o_mul_imm(mul_imm), .o_imm(imm), .o_daddr(daddr),
      .o_indirect(indirect), .o_aux_we(aux_we), .o_aux_sel(aux_sel), .o_aux_new(aux_new));
   always #25 i_clk = ~i_clk;
   // a hang past this ceiling is reported as one mismatch
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 1000) begin
         failures++;
         tally_and_finish();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask
   // outputs are sampled at the same small delay at which inputs change
   task automatic step;
      @(posedge i_clk);
      #2;
   endtask
   task automatic put(input logic [11:0] a, input logic [15:0] w);
      u_bmcd_prog_mem.mem[a] = w;
   endtask
   task automatic restart;
      step();
      i_resetn = 1'b0;
      for (int a = 0; a < 16; a++) begin
         put(a[11:0], 16'h7f80);
      end
      step();
      check({pc, busy, pulses}, 32'h0);
      i_resetn = 1'b1;
   endtask
   task automatic test_single;
      logic [15:0] ops [7] = '{16'h7f8f, 16'h6c05, 16'h6b12, 16'h6d33, 16'h8123, 16'h7f8e, 16'h7f90};
      logic [9:0] exp [7] = '{10'h200, 10'h208, 10'h20c, 10'h002, 10'h001, 10'h080, 10'h100};
      restart();
      for (int i = 0; i < 7; i++) begin
         put(i[11:0], ops[i]);
      end
      for (int i = 0; i < 7; i++) begin
         step();
         check(pc, i + 1);
         check(pulses, exp[i]);
         if (i == 3) check(daddr, 32'h33);
         if (i == 4) check(imm, 32'h123);
      end
      $display("test single-cycle ops done");
   endtask
   task automatic test_indirect;
      logic [15:0] ops [5] = '{16'h6ca1, 16'h6d90, 16'h6cb0, 16'h8030, 16'h6c20};
      // the pointer in force at fetch picks the register; bit 0 only steers the next access
      logic [15:0] nv [5] = '{16'h0011, 16'h00ff, 16'h0011, 16'h0, 16'h0};
      restart();
      i_aux0 = 16'h0010;
      i_aux1 = 16'h0100;
      for (int i = 0; i < 5; i++) begin
         put(i[11:0], ops[i]);
      end
      for (int i = 0; i < 5; i++) begin
         step();
         check(aux_we, i < 3);
         if (i < 3) check({indirect, aux_sel, aux_new}, {1'b1, (i == 1), nv[i]});
      end
      i_aux0 = 16'h0000;
      i_aux1 = 16'h0000;
      $display("test indirect aux update done");
   endtask
   task automatic test_two_cycle;
      logic [9:0] exp [2] = '{10'h020, 10'h040};
      restart();
      i_stack_top = 12'h2a5;
      put(12'h000, 16'h7f8d);
      step();
      check({pc, busy, pulses}, {12'h001, 1'b1, 10'h0});
      step();
      check({pc, pulses}, {12'h2a5, 10'h010});
      restart();
      put(12'h000, 16'h7f9c);
      put(12'h001, 16'h7f9d);
      for (int i = 0; i < 2; i++) begin
         step();
         check({busy, pulses}, {1'b1, 10'h0});
         step();
         check({pc, busy, pulses}, {12'(i + 1), 1'b0, exp[i]});
      end
      $display("test two-cycle ops done");
   endtask
   task automatic test_branch;
      logic [15:0] op [7] = '{16'hf400, 16'hf400, 16'hfa00, 16'hfa00, 16'hff00, 16'hff00, 16'hff00};
      logic [15:0] tg [7] = '{16'h0345, 16'h0345, 16'h0345, 16'h0345, 16'h0345, 16'h0345, 16'h1345};
      logic [2:0] fl [7] = '{3'b001, 3'b000, 3'b101, 3'b010, 3'b011, 3'b100, 3'b010};
      for (int i = 0; i < 7; i++) begin
         restart();
         i_acc_neg = fl[i][2];
         i_acc_zero = fl[i][1];
         i_aux0 = (i == 0) ? 16'h0005 : 16'h0000;
         put(12'h000, op[i]);
         put(12'h001, tg[i]);
         step();
         check({pc, busy}, {12'h001, 1'b1});
         step();
         check(pc, fl[i][0] ? 32'h345 : 32'h002);
         if (i == 0) check({aux_we, aux_new}, {1'b1, 16'h0004});
      end
      i_acc_neg = 1'b0;
      i_acc_zero = 1'b0;
      i_aux0 = 16'h0000;
      $display("test branches done");
   endtask
   task automatic test_freeze;
      restart();
      put(12'h000, 16'h7f8f);
      put(12'h001, 16'h7f8e);
      step();
      i_ce = 1'b0;
      step();
      step();
      check(pc, 32'h001);
      i_ce = 1'b1;
      step();
      check({pc, pulses}, {12'h002, 10'h080});
      $display("test clock enable freeze done");
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge i_clk);
      #2;
      i_resetn = 1'b1;
      test_single();
      test_indirect();
      test_two_cycle();
      test_branch();
      test_freeze();
      tally_and_finish();
   end
endmodule
`default_nettype wire
